/* rtl/sensor_ctl_pkg.sv */
package sensor_ctl_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_FREQ_MHZ       = 40;
    localparam int BOOT_TIME_NS       = 10000;
    localparam int WAKE_CMD_TIME_NS   = 10000;
    localparam int WAKE_MEAS_TIME_NS  = 20000;
    // least times: round up to whole cycles
    localparam int BOOT_CYCLES      = (BOOT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int WAKE_CMD_CYCLES  = (WAKE_CMD_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int WAKE_MEAS_CYCLES = (WAKE_MEAS_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int WAIT_W           = 16;

    // ****************************************
    // memory geometry
    // ****************************************
    localparam int PAGES      = 4;
    localparam int USER_WORDS = 24;
    localparam int RSV_WORDS  = 15;
    localparam int STEPS      = 4;
    localparam logic [15:0] RSV_STATUS = 16'h0001;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] READ_BASE        = 8'h00;
    localparam logic [7:0] STAT_BASE        = 8'h20;
    localparam logic [7:0] WRITE_BASE       = 8'h40;
    localparam logic [7:0] RSV_READ_BASE    = 8'h70;
    localparam logic [7:0] RSV_STAT_BASE    = 8'h80;
    localparam logic [7:0] USER_SPAN        = 8'h18;
    localparam logic [7:0] RSV_SPAN         = 8'h0f;
    localparam logic [7:0] PAGE_INC_CMD     = 8'h5e;
    localparam logic [7:0] ENTER_NORMAL_CMD = 8'ha8;
    localparam logic [7:0] ENTER_CONFIG_CMD = 8'ha9;
    localparam logic [7:0] MEASURE_CMD      = 8'hac;

    // ****************************************
    // status byte bits
    // ****************************************
    localparam int ST_MEM_FULL_BIT = 2;
    localparam int ST_BUSY_BIT     = 5;
    localparam int ST_CFG_MODE_BIT = 6;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        ROUTE_ANALOG_GROUND_REF   = 2'h0,
        ROUTE_BRIDGE = 2'h1,
        ROUTE_TEMP   = 2'h2
    } route_t;

    typedef struct packed {
        logic   temp_cfg;
        route_t route;
        logic   conv_start;
    } afe_ctl_t;

    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] data;
    } cmd_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [15:0] word;
    } resp_t;

    typedef enum logic [2:0] {
        ST_BOOT      = 3'h0,
        ST_SLEEP     = 3'h1,
        ST_WAKE_CMD  = 3'h2,
        ST_WAKE_MEAS = 3'h3,
        ST_CONV      = 3'h4,
        ST_CALC      = 3'h5,
        ST_ACTIVE    = 3'h6
    } state_t;
endpackage

/* rtl/level_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic resetn_in,
    // level
    input  wire logic level_in,
    output var  logic level_out
);
    logic first;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            first     <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            first     <= level_in;
            level_out <= first;
        end
    end
endmodule
`default_nettype wire

/* rtl/sensor_conditioner_control.sv */
`timescale 1ns/100ps
`default_nettype none
module sensor_conditioner_control #(
    parameter logic [sensor_ctl_pkg::RSV_WORDS*16-1:0] RSV_DATA = '0  // arbitrary factory contents
) (
    // clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    resetn_in,
    // interface select pin
    input  wire logic                    sel_pin_in,
    // commands from the serial interface
    input  wire logic                    cmd_valid_in,
    input  wire sensor_ctl_pkg::cmd_t    cmd_in,
    output var  logic                    resp_valid_out,
    output var  sensor_ctl_pkg::resp_t   resp_out,
    // analog front end and converter
    output var  sensor_ctl_pkg::afe_ctl_t afe_out,
    input  wire logic                    adc_done_in,
    input  wire logic [15:0]             adc_word_in,
    // correction engine
    output var  logic                    calc_start_out,
    input  wire logic                    calc_done_in,
    output var  logic [3:0][15:0]        raw_out,
    // power and mode
    output var  logic                    low_voltage_core_out,
    output var  logic                    i2c_sel_out,
    output var  logic                    cmd_mode_out,
    output var  logic                    eoc_out
);
    import sensor_ctl_pkg::*;

    // ****************************************
    // state
    // ****************************************
    state_t            state, next_state;
    logic [WAIT_W-1:0] wait_cnt, next_wait_cnt;
    logic [1:0]        step, next_step;
    logic [2:0]        page_ptr, next_page_ptr;
    logic              first_seen, next_first_seen;
    logic              next_cmd_mode, next_eoc, next_i2c_sel, next_resp_valid;
    logic              next_calc_start, next_core;
    resp_t             next_resp;
    afe_ctl_t          next_afe;
    logic [3:0][15:0]  next_raw;
    logic              sel_sync;
    logic [15:0]       mem [PAGES][USER_WORDS];
    logic              written [PAGES][USER_WORDS];
    logic              wr_en;
    logic [1:0]        wr_page, rd_page;
    logic [4:0]        wr_addr;
    logic              mem_full, busy;
    logic [7:0]        ofs;

    level_sync #(
        .RESET_VAL (1'b1)  // open pin pulls up, so reset shows I2C
    ) u_sel_sync (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .level_in  (sel_pin_in),
        .level_out (sel_sync)
    );

    // pages run out once the pointer passes the last one
    assign mem_full = (page_ptr == 3'(PAGES));
    assign rd_page  = mem_full ? 2'(PAGES - 1) : page_ptr[1:0];
    assign busy     = (state != ST_SLEEP) && (state != ST_ACTIVE);

    function automatic afe_ctl_t step_afe(input logic [1:0] s, input logic start);
        afe_ctl_t a;
        a.temp_cfg   = s[1];
        a.conv_start = start;
        case (s)
            2'h1:    a.route = ROUTE_BRIDGE;
            2'h3:    a.route = ROUTE_TEMP;
            default: a.route = ROUTE_ANALOG_GROUND_REF;
        endcase
        return a;
    endfunction

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        next_state      = state;
        next_wait_cnt   = wait_cnt;
        next_step       = step;
        next_page_ptr   = page_ptr;
        next_first_seen = first_seen;
        next_cmd_mode   = cmd_mode_out;
        next_eoc        = eoc_out;
        next_i2c_sel    = i2c_sel_out;
        next_raw        = raw_out;
        next_calc_start = 1'b0;
        next_resp_valid = cmd_valid_in;
        next_resp       = '0;
        wr_en           = 1'b0;
        wr_page         = page_ptr[1:0];
        wr_addr         = 5'(cmd_in.code - WRITE_BASE);
        ofs             = 8'h00;
        case (state)
            ST_BOOT: begin
                // core powered while the interface setting is fetched, and in every state but ST_SLEEP
                if (wait_cnt == WAIT_W'(BOOT_CYCLES - 1)) begin
                    next_i2c_sel  = sel_sync;
                    next_state    = ST_SLEEP;
                    next_wait_cnt = '0;
                end else begin
                    next_wait_cnt = wait_cnt + 1'b1;
                end
            end
            ST_WAKE_CMD, ST_WAKE_MEAS: begin
                if ((state == ST_WAKE_CMD && wait_cnt == WAIT_W'(WAKE_CMD_CYCLES - 1)) ||
                    (state == ST_WAKE_MEAS && wait_cnt == WAIT_W'(WAKE_MEAS_CYCLES - 1))) begin
                    next_wait_cnt = '0;
                    next_step     = 2'h0;
                    next_state    = (state == ST_WAKE_CMD) ? ST_ACTIVE : ST_CONV;
                end else begin
                    next_wait_cnt = wait_cnt + 1'b1;
                end
            end
            ST_CONV: begin
                if (adc_done_in) begin
                    next_raw[step] = adc_word_in;
                    if (step == 2'(STEPS - 1)) begin
                        next_state      = ST_CALC;
                        next_calc_start = 1'b1;
                    end else begin
                        next_step = step + 1'b1;
                    end
                end
            end
            ST_CALC: begin
                if (calc_done_in) begin
                    next_eoc   = 1'b1;
                    next_state = cmd_mode_out ? ST_ACTIVE : ST_SLEEP;
                end
            end
            ST_SLEEP, ST_ACTIVE: begin
                if (cmd_valid_in) begin
                    next_first_seen = 1'b1;
                    if (cmd_in.code < READ_BASE + USER_SPAN) begin
                        ofs            = cmd_in.code - READ_BASE;
                        next_resp.word = mem[rd_page][ofs[4:0]];
                    end else if (cmd_in.code >= STAT_BASE &&
                                 cmd_in.code < STAT_BASE + USER_SPAN) begin
                        ofs            = cmd_in.code - STAT_BASE;
                        next_resp.word = 16'(written[rd_page][ofs[4:0]]);
                    end else if (cmd_in.code >= WRITE_BASE &&
                                 cmd_in.code < WRITE_BASE + USER_SPAN) begin
                        wr_en = cmd_mode_out && !mem_full;
                    end else if (cmd_mode_out && cmd_in.code >= RSV_READ_BASE &&
                                 cmd_in.code < RSV_READ_BASE + RSV_SPAN) begin
                        ofs            = cmd_in.code - RSV_READ_BASE;
                        next_resp.word = RSV_DATA[ofs[3:0]*16 +: 16];
                    end else if (cmd_mode_out && cmd_in.code >= RSV_STAT_BASE &&
                                 cmd_in.code < RSV_STAT_BASE + RSV_SPAN) begin
                        next_resp.word = RSV_STATUS;
                    end else if (cmd_in.code == PAGE_INC_CMD) begin
                        if (cmd_mode_out && !mem_full) begin
                            next_page_ptr = page_ptr + 1'b1;
                        end
                    end else if (cmd_in.code == ENTER_NORMAL_CMD) begin
                        if (cmd_mode_out) begin
                            next_cmd_mode = 1'b0;
                            next_state    = ST_SLEEP;
                        end
                    end else if (cmd_in.code == ENTER_CONFIG_CMD) begin
                        if (!cmd_mode_out && !first_seen) begin
                            next_cmd_mode = 1'b1;
                            next_state    = ST_WAKE_CMD;
                            next_wait_cnt = '0;
                        end
                    end else if (cmd_in.code == MEASURE_CMD) begin
                        next_eoc      = 1'b0;
                        next_step     = 2'h0;
                        next_wait_cnt = '0;
                        next_state    = (state == ST_SLEEP) ? ST_WAKE_MEAS : ST_CONV;
                    end
                    // anything else falls through and only sets first_seen
                end
            end
            default: begin
                next_state = ST_SLEEP;
            end
        endcase
        // commands during boot or a measurement only get a busy status
        next_resp.status[ST_BUSY_BIT]     = busy;
        next_resp.status[ST_CFG_MODE_BIT] = next_cmd_mode;
        next_resp.status[ST_MEM_FULL_BIT] = (next_page_ptr == 3'(PAGES));
        next_afe = step_afe(next_step, next_state == ST_CONV &&
                            (state != ST_CONV || adc_done_in));
        next_core = (next_state != ST_SLEEP);
        if (next_state != ST_CONV) begin
            next_afe = '0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // clk_in is the internal oscillator; resetn_in the supervisor
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state                <= ST_BOOT;
            wait_cnt             <= '0;
            step                 <= 2'h0;
            page_ptr             <= 3'h0;
            first_seen           <= 1'b0;
            cmd_mode_out         <= 1'b0;
            eoc_out              <= 1'b0;
            i2c_sel_out          <= 1'b1;
            raw_out              <= '0;
            calc_start_out       <= 1'b0;
            resp_valid_out       <= 1'b0;
            resp_out             <= '0;
            afe_out              <= '0;
            low_voltage_core_out <= 1'b1;
        end else begin
            state                <= next_state;
            wait_cnt             <= next_wait_cnt;
            step                 <= next_step;
            page_ptr             <= next_page_ptr;
            first_seen           <= next_first_seen;
            cmd_mode_out         <= next_cmd_mode;
            eoc_out              <= next_eoc;
            i2c_sel_out          <= next_i2c_sel;
            raw_out              <= next_raw;
            calc_start_out       <= next_calc_start;
            resp_valid_out       <= next_resp_valid;
            resp_out             <= next_resp;
            afe_out              <= next_afe;
            low_voltage_core_out <= next_core;
        end
    end

    // bits only go from 0 to 1; the first write to a word ORs onto zeros; no erase path
    always_ff @(posedge clk_in) begin
        if (wr_en) begin
            mem[wr_page][wr_addr] <= cmd_in.data |
                (written[wr_page][wr_addr] ? mem[wr_page][wr_addr] : 16'h0000);
        end
    end

    // flags live beside the array so status reads are defined after reset
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            written <= '{default: 1'b0};
        end else if (wr_en) begin
            written[wr_page][wr_addr] <= 1'b1;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_calc_end;
        state == ST_CALC && calc_done_in;
    endsequence
    sequence s_sleep_measure;
        state == ST_SLEEP && cmd_valid_in && cmd_in.code == MEASURE_CMD;
    endsequence
    property p_eoc_cause;
        $rose(eoc_out) |-> $past(state) == ST_CALC && $past(calc_done_in);
    endproperty
    a_eoc_cause: assert property (p_eoc_cause) else $error("eoc rose without calc");
    property p_calc_to_eoc;
        s_calc_end |=> eoc_out;
    endproperty
    a_calc_to_eoc: assert property (p_calc_to_eoc) else $error("eoc missing");
    property p_or_write;
        wr_en |=> ((mem[$past(wr_page)][$past(wr_addr)] & $past(cmd_in.data))
                   == $past(cmd_in.data));
    endproperty
    a_or_write: assert property (p_or_write) else $error("written bits lost");
    property p_full_refuse;
        mem_full |-> !wr_en;
    endproperty
    a_full_refuse: assert property (p_full_refuse) else $error("write when full");
    property p_sleep_core;
        state == ST_SLEEP |-> !low_voltage_core_out && afe_out == '0;
    endproperty
    a_sleep_core: assert property (p_sleep_core) else $error("core on in sleep");
    property p_wake_meas;
        s_sleep_measure |=> (state == ST_WAKE_MEAS) [*8];
    endproperty
    a_wake_meas: assert property (p_wake_meas) else $error("wake delay skipped");
    property p_bridge_route;
        state == ST_CONV && step == 2'h1 |-> afe_out.route == ROUTE_BRIDGE && !afe_out.temp_cfg;
    endproperty
    a_bridge_route: assert property (p_bridge_route) else $error("bridge route");
    property p_step_order;
        state == ST_CONV && adc_done_in && step != 2'h3 |=> step == $past(step) + 2'h1;
    endproperty
    a_step_order: assert property (p_step_order) else $error("step order");
    property p_cfg_first;
        $rose(cmd_mode_out) |-> !$past(first_seen) && $past(cmd_in.code) == ENTER_CONFIG_CMD;
    endproperty
    a_cfg_first: assert property (p_cfg_first) else $error("late config entry");
    property p_page_cause;
        page_ptr != $past(page_ptr) |-> $past(cmd_mode_out) && $past(cmd_in.code) == PAGE_INC_CMD;
    endproperty
    a_page_cause: assert property (p_page_cause) else $error("page moved");
endmodule
`default_nettype wire

/* testbench/adc_calc_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// converter and correction stand-in
// ****************************************
module adc_calc_model (
    // clock and pace
    input  wire logic                     clk_in,
    input  wire logic                     slow_in,
    // requests from the block
    input  wire sensor_ctl_pkg::afe_ctl_t afe_in,
    input  wire logic                     calc_start_in,
    // answers
    output var  logic                     adc_done_out,
    output var  logic [15:0]              adc_word_out,
    output var  logic                     calc_done_out
);
    import sensor_ctl_pkg::*;
    logic [1:0] step      = 2'h0;
    logic       calc      = 1'b0;
    int         countdown = 0;
    initial begin
        adc_done_out  = 1'b0;
        adc_word_out  = 16'h0000;
        calc_done_out = 1'b0;
    end
    // one answer per request; the word is only valid with its done pulse
    // the next start may come one cycle after a done, so it is looked for
    // at the same edge that releases the done
    always @(negedge clk_in) begin
        if (adc_done_out || calc_done_out) begin
            calc_done_out = 1'b0;
            adc_done_out  = 1'b0;
            // released word is scrambled so a late capture shows
            adc_word_out  = ~adc_word_out;
        end
        if (countdown == 1) begin
            calc_done_out = calc;
            adc_done_out  = !calc;
            adc_word_out  = {2'h0, step, 12'ha5a};
            step          = calc ? step : step + 2'h1;
        end
        if (countdown > 0) begin
            countdown--;
        end
        if (afe_in.conv_start === 1'b1 || calc_start_in === 1'b1) begin
            calc      = calc_start_in;
            countdown = slow_in ? 7 : 1;
        end
    end
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
module tb;
    import sensor_ctl_pkg::*;
    // ****************************************
    // wiring
    // ****************************************
    logic             clk_in       = 1'b0;
    logic             resetn_in    = 1'b0;
    logic             sel_pin_in   = 1'b0;
    logic             cmd_valid_in = 1'b0;
    logic             slow         = 1'b0;
    logic             early        = 1'b0;
    logic [11:0]      seq          = 12'h000;
    cmd_t             cmd_in       = '0;
    resp_t            rsp;
    resp_t            resp_out;
    afe_ctl_t         afe_out;
    logic             resp_valid_out;
    logic             adc_done_in;
    logic [15:0]      adc_word_in;
    logic             calc_start_out;
    logic             calc_done_in;
    logic [3:0][15:0] raw_out;
    logic             low_voltage_core_out;
    logic             i2c_sel_out;
    logic             cmd_mode_out;
    logic             eoc_out;
    int               err_total    = 0;
    int               checks_done  = 0;
    always #12.5 clk_in = ~clk_in;
    sensor_conditioner_control #(.RSV_DATA({RSV_WORDS{16'hc35a}})) sensor_conditioner_control_inst (
        .clk_in(clk_in), .resetn_in(resetn_in), .sel_pin_in(sel_pin_in),
        .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .resp_valid_out(resp_valid_out),
        .resp_out(resp_out), .afe_out(afe_out), .adc_done_in(adc_done_in),
        .adc_word_in(adc_word_in), .calc_start_out(calc_start_out),
        .calc_done_in(calc_done_in), .raw_out(raw_out),
        .low_voltage_core_out(low_voltage_core_out), .i2c_sel_out(i2c_sel_out),
        .cmd_mode_out(cmd_mode_out), .eoc_out(eoc_out));
    adc_calc_model adc_calc_model_inst (
        .clk_in(clk_in), .slow_in(slow), .afe_in(afe_out), .calc_start_in(calc_start_out),
        .adc_done_out(adc_done_in), .adc_word_out(adc_word_in), .calc_done_out(calc_done_in));
    // step log: {temp_cfg, route} of each started conversion
    always @(negedge clk_in) begin
        if (afe_out.conv_start === 1'b1) seq <= {seq[8:0], afe_out[3:1]};
        if (calc_start_out === 1'b1 && eoc_out !== 1'b0) early <= 1'b1;
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk_in);
        cmd_valid_in = 1'b1;
        cmd_in       = '{code: code, data: data};
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
        `CHK(resp_valid_out, 1'b1)
        rsp = resp_out;
    endtask
    task automatic power_up(input logic pin);
        resetn_in  = 1'b0;
        sel_pin_in = pin;
        repeat (2) @(negedge clk_in);
        `CHK(i2c_sel_out, 1'b1)
        `CHK(low_voltage_core_out, 1'b1)
        resetn_in = 1'b1;
        repeat (BOOT_CYCLES + 4) @(negedge clk_in);
        `CHK(i2c_sel_out, pin)
        `CHK(low_voltage_core_out, 1'b0)
        `CHK(cmd_mode_out, 1'b0)
    endtask
    task automatic measure();
        int n;
        seq   = 12'h000;
        early = 1'b0;
        send(MEASURE_CMD, 16'h0000);
        `CHK(eoc_out, 1'b0)
        n = 0;
        while (eoc_out !== 1'b1 && n < 4000) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 4000) begin
            err_total++;
            finish_test();
        end else begin
            `CHK(seq, 12'h066)
            `CHK(early, 1'b0)
            for (int i = 0; i < STEPS; i++) begin
                `CHK(raw_out[i], {4'(i), 12'ha5a})
            end
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        power_up(1'b0);
        send(ENTER_CONFIG_CMD, 16'h0000);
        `CHK(cmd_mode_out, 1'b1)
        repeat (WAKE_CMD_CYCLES + 4) @(negedge clk_in);
        send(WRITE_BASE + 8'h05, 16'h8421);
        send(WRITE_BASE + 8'h05, 16'h2286);
        send(WRITE_BASE + 8'h05, 16'ha6a7);
        send(READ_BASE + 8'h05, 16'h0000);
        `CHK(rsp.word, 16'ha6a7)
        send(STAT_BASE + 8'h05, 16'h0000);
        `CHK(rsp.word, 16'h0001)
        send(WRITE_BASE + 8'h17, 16'h8001);
        send(READ_BASE + 8'h17, 16'h0000);
        `CHK(rsp.word, 16'h8001)
        send(RSV_READ_BASE + 8'h0e, 16'h0000);
        `CHK(rsp.word, 16'hc35a)
        send(RSV_STAT_BASE + 8'h0e, 16'h0000);
        `CHK(rsp.word, RSV_STATUS)
        `CHK(rsp.status[ST_CFG_MODE_BIT], 1'b1)
        send(8'hff, 16'hffff);
        `CHK(rsp.word, 16'h0000)
        slow = 1'b1;
        measure();
        `CHK(low_voltage_core_out, 1'b1)
        slow = 1'b0;
        // host moves to a fresh page before writing again
        repeat (3) send(PAGE_INC_CMD, 16'h0000);
        send(WRITE_BASE + 8'h05, 16'h00f0);
        `CHK(rsp.status[ST_MEM_FULL_BIT], 1'b0)
        send(READ_BASE + 8'h05, 16'h0000);
        `CHK(rsp.word, 16'h00f0)
        send(PAGE_INC_CMD, 16'h0000);
        send(WRITE_BASE + 8'h05, 16'h0f00);
        `CHK(rsp.status[ST_MEM_FULL_BIT], 1'b1)
        send(READ_BASE + 8'h05, 16'h0000);
        `CHK(rsp.word, 16'h00f0)
        send(ENTER_NORMAL_CMD, 16'h0000);
        `CHK(cmd_mode_out, 1'b0)
        send(ENTER_CONFIG_CMD, 16'h0000);
        `CHK(cmd_mode_out, 1'b0)
        send(RSV_READ_BASE, 16'h0000);
        `CHK(rsp.word, 16'h0000)
        measure();
        repeat (4) @(negedge clk_in);
        `CHK(low_voltage_core_out, 1'b0)
        power_up(1'b1);
        send(WRITE_BASE, 16'hffff);
        send(STAT_BASE, 16'h0000);
        `CHK(rsp.word, 16'h0000)
        send(ENTER_CONFIG_CMD, 16'h0000);
        `CHK(cmd_mode_out, 1'b0)
        measure();
        finish_test();
    end
endmodule
`default_nettype wire
